// ### out_term_params.svh
// constants for the output terminal function selector
`ifndef OUT_TERM_PARAMS_SVH
`define OUT_TERM_PARAMS_SVH

// number of digital output terminals
`define NUM_TERM       5
// width of one function selection code
`define SEL_W          5
// value widths from the control core
`define FREQ_W         16
`define CNT_W          16
`define TIME_W         16
`define AIN_W          12
`define OVL_W          16

// clock rate
`define CLK_HZ         40000000
// program-cycle pulse width in ms and in cycles (exact at 40 MHz)
`define PULSE_MS       250
`define PULSE_CYCLES   ((`CLK_HZ / 1000) * `PULSE_MS)
`define PULSE_CNT_W    24
// drive overload warning lead time in s, compared in ms
`define OVL_WARN_S     10
`define OVL_WARN_MS    (`OVL_WARN_S * 1000)

// reset value of every terminal
`define TERM_RESET     1'b0

`endif

// ### out_term_pkg.sv
// types shared by the output terminal function selector
`include "out_term_params.svh"

package out_term_pkg;

  // function selection codes, one per terminal
  typedef enum logic [`SEL_W-1:0] {
    sel_none         = 5'h00,
    sel_running      = 5'h01,
    sel_fault_stop   = 5'h02,
    sel_level_one    = 5'h03,
    sel_freq_reached = 5'h04,
    sel_zero_run     = 5'h05,
    sel_motor_ovl    = 5'h06,
    sel_drive_ovl    = 5'h07,
    sel_count_set    = 5'h08,
    sel_count_desig  = 5'h09,
    sel_length       = 5'h0A,
    sel_cycle_done   = 5'h0B,
    sel_run_time     = 5'h0C,
    sel_freq_limited = 5'h0D,
    sel_torque_limit = 5'h0E,
    sel_ready        = 5'h0F,
    sel_ain_compare  = 5'h10,
    sel_upper_limit  = 5'h11,
    sel_lower_limit  = 5'h12,
    sel_undervoltage = 5'h13,
    sel_host         = 5'h14,
    sel_reserved_a   = 5'h15,
    sel_reserved_b   = 5'h16,
    sel_zero_run_two = 5'h17,
    sel_power_time   = 5'h18,
    sel_level_two    = 5'h19
  } func_sel_t;

  // one code per terminal
  typedef func_sel_t [`NUM_TERM-1:0] sel_vec_t;

  // single-bit conditions from the control core
  typedef struct packed {
    logic running;          // drive running with output
    logic fault_stop;       // stopped by a fault
    logic level_one;        // first frequency-level detector
    logic level_two;        // second frequency-level detector
    logic freq_reached;     // frequency-reached detector
    logic motor_ovl_warn;   // motor load above pre-warning level
    logic ovl_pending;      // drive overload accumulating
    logic speed_mode;       // speed control mode active
    logic torque_at_limit;  // output torque at its limit
    logic stall_active;     // stall protection entered
    logic main_stable;      // main circuit stable
    logic ctrl_stable;      // control circuit stable
    logic fault_detected;   // any fault present
    logic run_ready;        // drive accepts a run command
    logic undervoltage;     // bus undervoltage state
    logic cycle_done;       // one-cycle event: program cycle done
  } drive_flags_t;

  // measured values and thresholds from the control core
  typedef struct packed {
    logic [`OVL_W-1:0]  ovl_left_ms;      // time to overload action
    logic [`FREQ_W-1:0] out_freq;         // output frequency
    logic [`FREQ_W-1:0] set_freq;         // set frequency
    logic [`FREQ_W-1:0] freq_upper;       // upper frequency limit
    logic [`FREQ_W-1:0] freq_lower;       // lower frequency limit
    logic [`CNT_W-1:0]  count_value;      // counter value
    logic [`CNT_W-1:0]  count_set;        // set count value
    logic [`CNT_W-1:0]  count_desig;      // designated count value
    logic [`CNT_W-1:0]  length_actual;    // measured length
    logic [`CNT_W-1:0]  length_set;       // length setpoint
    logic [`TIME_W-1:0] run_time;         // accumulated running time
    logic [`TIME_W-1:0] run_time_limit;   // running time threshold
    logic [`TIME_W-1:0] power_time;       // accumulated power-on time
    logic [`TIME_W-1:0] power_time_limit; // power-on time threshold
    logic [`AIN_W-1:0]  ain_one;          // first analog input
    logic [`AIN_W-1:0]  ain_two;          // second analog input
  } drive_values_t;

  // pulse stretcher phases
  typedef enum logic {
    ph_idle   = 1'b0,
    ph_active = 1'b1
  } pulse_phase_t;

  // whole state of the pulse stretcher
  typedef struct packed {
    pulse_phase_t            phase;
    logic [`PULSE_CNT_W-1:0] left;
    logic                    pulse;
  } pulse_state_t;

  // whole state of the selector
  typedef struct packed {
    logic [`NUM_TERM-1:0] term;
  } sel_state_t;

endpackage

// ### cycle_pulse.sv
// fixed-width pulse generator for the program-cycle-complete event
`timescale 1ns/10ps
`include "out_term_params.svh"

module cycle_pulse #(
  parameter int unsigned PULSE_CYCLES = `PULSE_CYCLES
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // event in, stretched pulse out
  input  wire logic trigger_i,
  output logic      pulse_o
);

  out_term_pkg::pulse_state_t state;       // registered state
  out_term_pkg::pulse_state_t next_state;  // next value

  // a new event restarts the full width, so back to back cycles
  // never shorten a pulse below its width
  always_comb begin
    next_state = state;
    unique case (state.phase)
      out_term_pkg::ph_idle: begin
        if (trigger_i) begin
          next_state.phase = out_term_pkg::ph_active;
          next_state.left  = `PULSE_CNT_W'(PULSE_CYCLES - 1);
          next_state.pulse = 1'b1;
        end
      end
      out_term_pkg::ph_active: begin
        if (trigger_i) begin
          next_state.left = `PULSE_CNT_W'(PULSE_CYCLES - 1);
        end else if (state.left == '0) begin
          next_state.phase = out_term_pkg::ph_idle;
          next_state.pulse = 1'b0;
        end else begin
          next_state.left = state.left - 1'b1;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign pulse_o = state.pulse;

  a_pulse_start: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    trigger_i |=> pulse_o && state.left == `PULSE_CNT_W'(PULSE_CYCLES - 1))
    else $error("pulse did not start at full width");

  a_pulse_hold: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    pulse_o && state.left != '0 |=> pulse_o)
    else $error("pulse ended early");

  a_pulse_end: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    pulse_o && state.left == '0 && !trigger_i |=> !pulse_o)
    else $error("pulse ran past its width");

endmodule

// ### output_terminal_function_select.sv
// per-terminal function selector for the digital output terminals
// Behaviour
// - each terminal follows its own code
// - code 0 holds the terminal off
// - code 1 on while running, zero frequency too
// - code 2 on after a fault stop
// - codes 3 and 25 pass level detectors
// - code 4 passes frequency reached
// - code 5 on at zero speed, off stopped
// - code 6 on at motor overload pre-warning
// - code 7 on 10 s before overload
// - codes 8 and 9 on at count targets
// - code 10 on when length exceeds setpoint
// - code 11 gives 250 ms cycle pulse
// - code 12 on past running time threshold
// - code 13 on when frequency is limited
// - code 14 on at torque limit stall, in speed control mode only
// - code 15 on when ready to run
// - code 16 on when analog one exceeds two
// - code 17 on at upper frequency limit
// - code 18 on at lower limit, off stopped
// - code 19 on during undervoltage
// - code 20 follows the host command
// - code 23 on at zero frequency or stop
// - code 24 on past power-on time threshold
`timescale 1ns/10ps
`include "out_term_params.svh"

module output_terminal_function_select #(
  // pulse width in cycles, shortened in simulation
  parameter int unsigned PULSE_CYCLES = `PULSE_CYCLES
) (
  // clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  // function selection per terminal
  input  wire out_term_pkg::sel_vec_t      func_sel_i,
  // drive status from the control core
  input  wire out_term_pkg::drive_flags_t  flags_i,
  input  wire out_term_pkg::drive_values_t values_i,
  // host-commanded terminal states
  input  wire logic [`NUM_TERM-1:0]        host_cmd_i,
  // terminal drive, high means ON
  output logic      [`NUM_TERM-1:0]        term_o
);

  out_term_pkg::sel_state_t state;       // registered terminal states
  out_term_pkg::sel_state_t next_state;  // next value

  // shared conditions, computed once for all terminals
  logic                 zero_freq;       // output frequency is zero
  logic                 zero_run;        // running at zero frequency
  logic                 drive_ovl_soon;  // overload action within 10 s
  logic                 count_set_hit;   // counter at set value
  logic                 count_desig_hit; // counter at designated value
  logic                 length_hit;      // length beyond setpoint
  logic                 run_time_hit;    // running time beyond limit
  logic                 power_time_hit;  // power-on time beyond limit
  logic                 freq_limited;    // set frequency clipped
  logic                 torque_limited;  // torque limit stall
  logic                 ready_to_run;    // ready for a run command
  logic                 ain_greater;     // analog one above analog two
  logic                 at_upper;        // running at upper limit
  logic                 at_lower;        // running at lower limit
  logic                 zero_or_stop;    // zero frequency or stopped
  logic                 cycle_pulse_on;  // stretched cycle pulse
  logic [`NUM_TERM-1:0] cond;            // selected condition per term

  // zero-speed conditions; code 5 needs running, code 23 does not
  assign zero_freq    = (values_i.out_freq == '0);
  assign zero_run     = flags_i.running && zero_freq;
  assign zero_or_stop = zero_freq || !flags_i.running;

  // the core reports the time left before the overload action; the
  // warning lead time is a fixed figure, not a user setting
  assign drive_ovl_soon = flags_i.ovl_pending &&
    (values_i.ovl_left_ms <= `OVL_W'(`OVL_WARN_MS));

  // counter targets count as reached once the value gets there
  assign count_set_hit   =
    (values_i.count_value >= values_i.count_set);
  assign count_desig_hit =
    (values_i.count_value >= values_i.count_desig);

  // length and time thresholds must be strictly exceeded
  assign length_hit     =
    (values_i.length_actual > values_i.length_set);
  assign run_time_hit   =
    (values_i.run_time > values_i.run_time_limit);
  assign power_time_hit =
    (values_i.power_time > values_i.power_time_limit);

  // set frequency outside a limit and output pinned at that limit
  assign freq_limited =
    ((values_i.set_freq > values_i.freq_upper) &&
     (values_i.out_freq >= values_i.freq_upper)) ||
    ((values_i.set_freq < values_i.freq_lower) &&
     (values_i.out_freq <= values_i.freq_lower));

  // torque limit only counts in speed control mode
  assign torque_limited = flags_i.speed_mode &&
    flags_i.torque_at_limit && flags_i.stall_active;

  // both circuits stable, no fault, run accepted
  assign ready_to_run = flags_i.main_stable && flags_i.ctrl_stable &&
    !flags_i.fault_detected && flags_i.run_ready;

  // unsigned compare of the two analog samples
  assign ain_greater = (values_i.ain_one > values_i.ain_two);

  // limit-reached codes are off while stopped
  assign at_upper = flags_i.running &&
    (values_i.out_freq >= values_i.freq_upper);
  assign at_lower = flags_i.running &&
    (values_i.out_freq <= values_i.freq_lower);

  // one stretcher serves every terminal on code 11, so all such
  // terminals show the very same pulse
  cycle_pulse #(
    .PULSE_CYCLES (PULSE_CYCLES)
  ) u_cycle_pulse (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .trigger_i (flags_i.cycle_done),
    .pulse_o   (cycle_pulse_on)
  );

  // one selector per terminal, each reading only its own code
  for (genvar t = 0; t < `NUM_TERM; t++) begin : g_term
    logic sel;  // condition chosen by this terminal's code

    // codes above 25 are illegal and read as no output
    always_comb begin
      sel = 1'b0;
      unique case (func_sel_i[t])
        out_term_pkg::sel_none:         sel = 1'b0;
        out_term_pkg::sel_running:      sel = flags_i.running;
        out_term_pkg::sel_fault_stop:   sel = flags_i.fault_stop;
        out_term_pkg::sel_level_one:    sel = flags_i.level_one;
        out_term_pkg::sel_freq_reached: sel = flags_i.freq_reached;
        out_term_pkg::sel_zero_run:     sel = zero_run;
        out_term_pkg::sel_motor_ovl:    sel = flags_i.motor_ovl_warn;
        out_term_pkg::sel_drive_ovl:    sel = drive_ovl_soon;
        out_term_pkg::sel_count_set:    sel = count_set_hit;
        out_term_pkg::sel_count_desig:  sel = count_desig_hit;
        out_term_pkg::sel_length:       sel = length_hit;
        out_term_pkg::sel_cycle_done:   sel = cycle_pulse_on;
        out_term_pkg::sel_run_time:     sel = run_time_hit;
        out_term_pkg::sel_freq_limited: sel = freq_limited;
        out_term_pkg::sel_torque_limit: sel = torque_limited;
        out_term_pkg::sel_ready:        sel = ready_to_run;
        out_term_pkg::sel_ain_compare:  sel = ain_greater;
        out_term_pkg::sel_upper_limit:  sel = at_upper;
        out_term_pkg::sel_lower_limit:  sel = at_lower;
        out_term_pkg::sel_undervoltage: sel = flags_i.undervoltage;
        out_term_pkg::sel_host:         sel = host_cmd_i[t];
        out_term_pkg::sel_reserved_a:   sel = 1'b0;
        out_term_pkg::sel_reserved_b:   sel = 1'b0;
        out_term_pkg::sel_zero_run_two: sel = zero_or_stop;
        out_term_pkg::sel_power_time:   sel = power_time_hit;
        out_term_pkg::sel_level_two:    sel = flags_i.level_two;
        default:                        sel = 1'b0;
      endcase
    end

    assign cond[t] = sel;

    // code 0 stays off
    a_none_off: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      func_sel_i[t] == out_term_pkg::sel_none |=> !term_o[t])
      else $error("terminal on with no function");

    // code 1 tracks run
    a_run_follow: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      func_sel_i[t] == out_term_pkg::sel_running |=>
        term_o[t] == $past(flags_i.running))
      else $error("running terminal does not follow run state");

    // code 2 tracks fault
    a_fault_follow: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      func_sel_i[t] == out_term_pkg::sel_fault_stop |=>
        term_o[t] == $past(flags_i.fault_stop))
      else $error("fault terminal does not follow fault stop");

    // code 5 off stopped
    a_zero_stop: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      func_sel_i[t] == out_term_pkg::sel_zero_run && !flags_i.running
        |=> !term_o[t])
      else $error("zero speed terminal on while stopped");

    // code 18 off stopped
    a_lower_stop: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      func_sel_i[t] == out_term_pkg::sel_lower_limit && !flags_i.running
        |=> !term_o[t])
      else $error("lower limit terminal on while stopped");

    // code 23 on stopped
    a_zero_two_stop: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      func_sel_i[t] == out_term_pkg::sel_zero_run_two &&
        !flags_i.running |=> term_o[t])
      else $error("zero speed two terminal off while stopped");

    // code 19 undervoltage
    a_under_follow: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      func_sel_i[t] == out_term_pkg::sel_undervoltage |=>
        term_o[t] == $past(flags_i.undervoltage))
      else $error("undervoltage terminal wrong");

    // code 20 host bit
    a_host_follow: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      func_sel_i[t] == out_term_pkg::sel_host |=>
        term_o[t] == $past(host_cmd_i[t]))
      else $error("host terminal does not follow command");

    // reserved codes off
    a_reserved_off: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (func_sel_i[t] == out_term_pkg::sel_reserved_a ||
       func_sel_i[t] == out_term_pkg::sel_reserved_b) |=> !term_o[t])
      else $error("terminal on with reserved code");

    // code 16 analog compare
    a_ain_follow: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      func_sel_i[t] == out_term_pkg::sel_ain_compare |=>
        term_o[t] ==
          ($past(values_i.ain_one) > $past(values_i.ain_two)))
      else $error("analog compare terminal wrong");

    // code 7 on at the lead
    a_ovl_lead: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      func_sel_i[t] == out_term_pkg::sel_drive_ovl &&
        flags_i.ovl_pending &&
        values_i.ovl_left_ms == `OVL_W'(`OVL_WARN_MS)
        |=> term_o[t])
      else $error("overload warning missing at 10 s lead");

    // code 3 level one
    a_level_one: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      func_sel_i[t] == out_term_pkg::sel_level_one |=>
        term_o[t] == $past(flags_i.level_one))
      else $error("level one terminal wrong");

    // code 25 level two
    a_level_two: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      func_sel_i[t] == out_term_pkg::sel_level_two |=>
        term_o[t] == $past(flags_i.level_two))
      else $error("level two terminal wrong");

    // code 4 reached
    a_reach_follow: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      func_sel_i[t] == out_term_pkg::sel_freq_reached |=>
        term_o[t] == $past(flags_i.freq_reached))
      else $error("reached terminal wrong");

    // code 6 motor warning
    a_motor_follow: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      func_sel_i[t] == out_term_pkg::sel_motor_ovl |=>
        term_o[t] == $past(flags_i.motor_ovl_warn))
      else $error("motor warning terminal wrong");

    // code 8 set count
    a_count_hit: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      func_sel_i[t] == out_term_pkg::sel_count_set &&
        values_i.count_value >= values_i.count_set |=> term_o[t])
      else $error("count terminal off");

    // code 10 length
    a_length_hit: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      func_sel_i[t] == out_term_pkg::sel_length &&
        values_i.length_actual > values_i.length_set |=> term_o[t])
      else $error("length terminal off");

    // code 12 running time
    a_run_time_hit: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      func_sel_i[t] == out_term_pkg::sel_run_time &&
        values_i.run_time > values_i.run_time_limit |=> term_o[t])
      else $error("running time terminal off");

    // code 24 power-on time
    a_power_hit: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      func_sel_i[t] == out_term_pkg::sel_power_time &&
        values_i.power_time > values_i.power_time_limit |=> term_o[t])
      else $error("power-on terminal off");

    // code 14 needs speed mode
    a_torque_mode: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      func_sel_i[t] == out_term_pkg::sel_torque_limit &&
        !flags_i.speed_mode |=> !term_o[t])
      else $error("torque terminal on off mode");

    // code 15 ready
    a_ready_on: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      func_sel_i[t] == out_term_pkg::sel_ready && flags_i.run_ready &&
        flags_i.main_stable && flags_i.ctrl_stable &&
        !flags_i.fault_detected |=> term_o[t])
      else $error("ready terminal off");

    // code 17 upper limit
    a_upper_on: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      func_sel_i[t] == out_term_pkg::sel_upper_limit && flags_i.running &&
        values_i.out_freq >= values_i.freq_upper |=> term_o[t])
      else $error("upper limit terminal off");
  end

  // all terminals re-evaluated every cycle
  always_comb begin
    next_state      = state;
    next_state.term = cond;
  end

  // terminal register; outputs come straight from here
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state.term <= {`NUM_TERM{`TERM_RESET}};
    end else begin
      state <= next_state;
    end
  end

  assign term_o = state.term;

  // a new code shows one edge later
  a_code_change: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    $changed(func_sel_i) |=> term_o == $past(cond))
    else $error("code change not applied on next cycle");

endmodule

// ### field_wiring.sv
// field wiring model: open-collector terminals seen through pull-ups
`timescale 1ns/10ps
`include "out_term_params.svh"

module field_wiring (
  // terminal drive from the device, high means conducting
  input  wire logic [`NUM_TERM-1:0] term_i,
  // sensed line level, low while the terminal conducts
  output logic      [`NUM_TERM-1:0] line_n_o
);
  // an off transistor lets the pull-up win, so idle lines read high
  assign line_n_o = ~term_i;
endmodule

// ### test_output_terminal_function_select.sv
// self-checking bench for the output terminal function selector
`timescale 1ns/10ps
`include "out_term_params.svh"

module test_output_terminal_function_select;
  localparam int unsigned PULSE = 20;   // shortened cycle pulse
  localparam int unsigned LIMIT = 2000; // cycle ceiling for a hang
  localparam logic [4:0]  ALL   = 5'h1F; // every terminal on
  localparam logic [4:0]  NONE  = 5'h00; // every terminal off

  logic                        clk_i;      // 40 MHz clock
  logic                        rst_n_i;    // active-low reset
  out_term_pkg::sel_vec_t      func_sel_i; // code per terminal
  out_term_pkg::drive_flags_t  flags_i;    // core status bits
  out_term_pkg::drive_values_t values_i;   // core values
  logic [`NUM_TERM-1:0]        host_cmd_i; // host-commanded states
  logic [`NUM_TERM-1:0]        term_o;     // terminal drive
  logic [`NUM_TERM-1:0]        line_n;     // wiring level
  out_term_pkg::drive_flags_t  f;          // flags for the next case
  out_term_pkg::drive_values_t v;          // values for the next case
  int                          fail_count; // mismatches seen
  int                          n_checks;   // comparisons made
  int                          cycles;     // elapsed clock cycles

  output_terminal_function_select #(
    .PULSE_CYCLES (PULSE)
  ) i_output_terminal_function_select (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .func_sel_i (func_sel_i),
    .flags_i    (flags_i),
    .values_i   (values_i),
    .host_cmd_i (host_cmd_i),
    .term_o     (term_o)
  );

  field_wiring i_field_wiring (
    .term_i   (term_o),
    .line_n_o (line_n)
  );

  // free-running clock, 25 ns period
  always #12.5 clk_i = ~clk_i;

  // cycle ceiling cuts a hang short
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fail_count++;
      $display("MISMATCH t=%0t run did not finish", $time);
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // terminal pattern, also seen on the wiring as the inverse
  task automatic check_term(input logic [`NUM_TERM-1:0] exp);
    n_checks++;
    if (term_o !== exp || line_n !== ~exp) begin
      fail_count++;
      $display("MISMATCH t=%0t term %b want %b", $time, term_o, exp);
    end
  endtask

  // measured count against its expectation
  task automatic check_count(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      fail_count++;
      $display("MISMATCH t=%0t count %0d want %0d", $time, got, exp);
    end
  endtask

  // one code on every terminal; result judged one edge later
  task automatic run_case(input logic [4:0] c, input logic [4:0] h,
                          input logic [4:0] exp);
    @(posedge clk_i);
    func_sel_i <= out_term_pkg::sel_vec_t'({`NUM_TERM{c}});
    flags_i <= f;
    values_i <= v;
    host_cmd_i <= h;
    @(posedge clk_i);
    @(negedge clk_i);
    check_term(exp);
  endtask

  // single-flag codes: only their own flag may turn them on
  task automatic t_single_flags();
    logic [4:0] c [7] = '{5'h01, 5'h02, 5'h03, 5'h19, 5'h04, 5'h06, 5'h13};
    int         b [7] = '{15, 14, 13, 12, 11, 10, 1};
    v = '0;
    for (int i = 0; i < 7; i++) begin
      f = out_term_pkg::drive_flags_t'(16'h0001 << b[i]);
      run_case(c[i], NONE, ALL);
      f = ~f;
      run_case(c[i], ALL, NONE);
    end
  endtask

  // count, length, time and analog boundaries
  task automatic t_thresholds();
    f = '0;
    v = '0;
    v.count_value = 16'h0064;
    v.count_set = 16'h0064;
    v.count_desig = 16'h0065;
    run_case(5'h08, NONE, ALL);
    run_case(5'h09, NONE, NONE);
    v.length_actual = 16'h0200;
    v.length_set = 16'h0200;
    v.run_time = 16'h0300;
    v.run_time_limit = 16'h0300;
    v.power_time = 16'h0400;
    v.power_time_limit = 16'h0400;
    v.ain_one = 12'h800;
    v.ain_two = 12'h800;
    run_case(5'h0A, NONE, NONE);
    run_case(5'h0C, NONE, NONE);
    run_case(5'h18, NONE, NONE);
    run_case(5'h10, NONE, NONE);
    v.length_actual++;
    v.run_time++;
    v.power_time++;
    v.ain_one++;
    run_case(5'h0A, NONE, ALL);
    run_case(5'h0C, NONE, ALL);
    run_case(5'h18, NONE, ALL);
    run_case(5'h10, NONE, ALL);
    f.ovl_pending = 1'b1;
    v.ovl_left_ms = 16'h2710;
    run_case(5'h07, NONE, ALL);
    v.ovl_left_ms = 16'h2711;
    run_case(5'h07, NONE, NONE);
  endtask

  // frequency, stop-state, torque and readiness codes
  task automatic t_frequency();
    f = '0;
    v = '0;
    v.freq_upper = 16'h1000;
    v.freq_lower = 16'h0100;
    f.running = 1'b1;
    run_case(5'h05, NONE, ALL);
    run_case(5'h17, NONE, ALL);
    f.running = 1'b0;
    run_case(5'h05, NONE, NONE);
    v.out_freq = 16'h0100;
    run_case(5'h17, NONE, ALL);
    run_case(5'h12, NONE, NONE);
    f.running = 1'b1;
    run_case(5'h12, NONE, ALL);
    run_case(5'h05, NONE, NONE);
    run_case(5'h17, NONE, NONE);
    v.set_freq = 16'h0080;
    run_case(5'h0D, NONE, ALL);
    v.out_freq = 16'h1000;
    run_case(5'h11, NONE, ALL);
    run_case(5'h0D, NONE, NONE);
    v.set_freq = 16'h2000;
    run_case(5'h0D, NONE, ALL);
    v.out_freq = 16'h0FFF;
    run_case(5'h11, NONE, NONE);
    f = '0;
    f.speed_mode = 1'b1;
    f.torque_at_limit = 1'b1;
    f.stall_active = 1'b1;
    run_case(5'h0E, NONE, ALL);
    f.speed_mode = 1'b0;
    run_case(5'h0E, NONE, NONE);
    f = '0;
    f.main_stable = 1'b1;
    f.ctrl_stable = 1'b1;
    f.run_ready = 1'b1;
    run_case(5'h0F, NONE, ALL);
    f.fault_detected = 1'b1;
    run_case(5'h0F, NONE, NONE);
  endtask

  // host codes, unused codes and per-terminal selection
  task automatic t_host_and_mix();
    f = '1;
    v = '1;
    run_case(5'h00, ALL, NONE);
    run_case(5'h15, ALL, NONE);
    run_case(5'h16, ALL, NONE);
    run_case(5'h1F, ALL, NONE);
    run_case(5'h14, 5'h15, 5'h15);
    run_case(5'h14, 5'h0A, 5'h0A);
    @(posedge clk_i);
    func_sel_i <= out_term_pkg::sel_vec_t'({5'h13, 5'h14, 5'h00,
                                            5'h02, 5'h01});
    flags_i <= out_term_pkg::drive_flags_t'(16'h8002);
    host_cmd_i <= 5'h08;
    @(posedge clk_i);
    @(negedge clk_i);
    check_term(5'h19);
  endtask

  // program-cycle event gives one pulse of fixed width
  task automatic t_cycle_pulse();
    int n;
    n = 0;
    f = '0;
    // let the last pulse run out
    repeat (PULSE) @(posedge clk_i);
    run_case(5'h0B, NONE, NONE);
    @(posedge clk_i);
    flags_i.cycle_done <= 1'b1;
    @(posedge clk_i);
    flags_i.cycle_done <= 1'b0;
    repeat (3 * PULSE) begin
      @(negedge clk_i);
      if (term_o === ALL) begin
        n++;
      end
    end
    check_count(n, PULSE);
    check_term(NONE);
  endtask

  initial begin
    clk_i = 1'b0;
    rst_n_i = 1'b0;
    func_sel_i = out_term_pkg::sel_vec_t'(25'h0000000);
    flags_i = '0;
    values_i = '0;
    host_cmd_i = '0;
    fail_count = 0;
    n_checks = 0;
    cycles = 0;
    repeat (6) @(posedge clk_i);
    check_term(NONE);
    rst_n_i <= 1'b1;
    t_single_flags();
    t_thresholds();
    t_frequency();
    t_host_and_mix();
    t_cycle_pulse();
    print_verdict();
  end
endmodule
